// ### comp_if.sv
// Link between the bank and its current-sense compensation stage
`timescale 1ns/100ps
interface comp_if #(parameter int W = 16);
  logic [7:0] temp;
  logic [W-1:0] raw;
  logic [7:0] level1;
  logic [7:0] level2;
  logic [7:0] factor1;
  logic [7:0] factor2;
  logic [W-1:0] result;
  modport src (output temp, raw, level1, level2, factor1, factor2,
               input result);
  modport comp (input temp, raw, level1, level2, factor1, factor2,
                output result);
endinterface

// ### converter_mfr_config_bank.sv
// Manufacturer configuration and calibration command bank
//
// Behaviour
// - Options bit 7 requires packet error checking
// - Options bit 5 picks linear/non-linear droop
// - Options bit 3 enables adaptive ramp/loop
// - Options bit 2 enables dynamic bus voltage
// - Options bits 0 and 1 reserved
// - Internal temp offset: read-only 16-bit word
// - Sensor calibration: read-only offset then slope
// - Remote bit 4 selects OR or AND
// - Remote bit 2 enables remote pin
// - Remote bit 1 sets pin polarity
// - Remote bit 0 soft-stop or quick-off
// - Feed-forward block: four read/write bytes
// - Temp coefficient: read-only six-byte block
// - Above level apply factor to current
`timescale 1ns/100ps
module converter_mfr_config_bank
  import mfr_config_pkg::*;
#(
  parameter int IW = 16,
  parameter logic [15:0] TEMP_OFFSET = TEMP_OFFSET_DEFAULT,
  parameter logic [31:0] SENSOR_CAL = SENSOR_CAL_DEFAULT,
  parameter logic [47:0] TEMP_COEFF = TEMP_COEFF_DEFAULT
)
(
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Command byte access from the bus transaction layer
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic [7:0] acc_code_in,
  input wire logic [2:0] acc_index_in,
  input wire logic [7:0] acc_wdata_in,
  output logic acc_ack_out,
  output logic acc_err_out,
  output logic [7:0] acc_rdata_out,
  // On/off sources
  input wire logic operation_on_in,
  input wire logic ctrl_pin_in,
  input wire logic primary_remote_pin_in,
  // Converter controls
  output logic output_enable_out,
  output logic quick_off_out,
  output logic pec_required_out,
  output logic droop_slope_select_out,
  output logic adaptive_ramp_loop_comp_out,
  output logic dynamic_bus_voltage_out,
  output logic [31:0] feed_forward_params_out,
  // Current sense path
  input wire logic [7:0] temperature_in,
  input wire logic [IW-1:0] current_sense_in,
  output logic [IW-1:0] output_current_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] spec;
    logic [7:0] rctl;
    logic [31:0] ff;
    logic [1:0] rc_sync;
    logic [1:0] ctl_sync;
    logic ack;
    logic err;
    logic [7:0] rdata;
    logic oe;
  } bank_state_t;

  bank_state_t q, d;
  logic [47:0] rvec;
  logic [2:0] len;
  logic known;
  logic writable;
  logic bad;
  logic base_on;
  logic rc_active;

  comp_if #(.W(IW)) cif ();

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  always_comb
  begin
    rvec = '0;
    len = 3'h0;
    known = 1'b1;
    writable = 1'b0;
    unique case (acc_code_in)
      CODE_SPECIAL_OPTIONS:
      begin
        rvec = {40'h0, q.spec};
        len = LEN_SPECIAL_OPTIONS;
        writable = 1'b1;
      end
      CODE_INTERNAL_TEMP_OFFSET:
      begin
        rvec = {32'h0, TEMP_OFFSET};
        len = LEN_INTERNAL_TEMP_OFFSET;
      end
      CODE_EXTERNAL_SENSOR_CAL:
      begin
        // Byte 0-1 offset, byte 2-3 slope
        rvec = {16'h0, SENSOR_CAL};
        len = LEN_EXTERNAL_SENSOR_CAL;
      end
      CODE_REMOTE_PIN_CONTROL:
      begin
        rvec = {40'h0, q.rctl};
        len = LEN_REMOTE_PIN_CONTROL;
        writable = 1'b1;
      end
      CODE_FEED_FORWARD_PARAMS:
      begin
        rvec = {16'h0, q.ff};
        len = LEN_FEED_FORWARD_PARAMS;
        writable = 1'b1;
      end
      CODE_CURRENT_SENSE_COMP:
      begin
        rvec = TEMP_COEFF;
        len = LEN_CURRENT_SENSE_COMP;
      end
      default:
        known = 1'b0;
    endcase
    // Writes to read-only bytes and out-of-range bytes are refused, never stored
    bad = !known || (acc_index_in >= len) || (acc_write_in && !writable);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    base_on = operation_on_in & q.ctl_sync[1];
    rc_active = (q.rc_sync[1] == q.rctl[RCTL_POL_BIT]);
    if (ce_in)
    begin
      d.rc_sync = {q.rc_sync[0], primary_remote_pin_in};
      d.ctl_sync = {q.ctl_sync[0], ctrl_pin_in};
      d.ack = acc_valid_in;
      d.err = acc_valid_in && bad;
      d.rdata = 8'h00;
      if (acc_valid_in && !bad && !acc_write_in)
        d.rdata = rvec[{acc_index_in, 3'b000} +: 8];
      if (acc_valid_in && !bad && acc_write_in)
      begin
        unique case (acc_code_in)
          CODE_SPECIAL_OPTIONS:
            d.spec = acc_wdata_in & SPEC_WRITE_MASK;
          CODE_REMOTE_PIN_CONTROL:
            d.rctl = acc_wdata_in & RCTL_WRITE_MASK;
          CODE_FEED_FORWARD_PARAMS:
            d.ff[{acc_index_in[1:0], 3'b000} +: 8] = acc_wdata_in;
          default:
            d.ff = q.ff;
        endcase
      end
      if (!q.rctl[RCTL_EN_BIT])
        d.oe = base_on;
      else if (q.rctl[RCTL_AND_BIT])
        d.oe = base_on & rc_active;
      else
        d.oe = base_on | rc_active;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
      q.spec <= SPEC_RESET;
      q.rctl <= RCTL_RESET;
      q.ff <= FEED_FORWARD_RESET;
    end
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // Compensation stage
  // ---------------------------------------------------------------
  assign cif.temp = temperature_in;
  assign cif.raw = current_sense_in;
  assign cif.level1 = TEMP_COEFF[23:16];
  assign cif.factor1 = TEMP_COEFF[31:24];
  assign cif.level2 = TEMP_COEFF[39:32];
  assign cif.factor2 = TEMP_COEFF[47:40];

  current_sense_comp #(.W(IW)) u_comp (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .link(cif)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign acc_ack_out = q.ack;
  assign acc_err_out = q.err;
  assign acc_rdata_out = q.rdata;
  assign output_enable_out = q.oe;
  assign quick_off_out = q.rctl[RCTL_QUICK_BIT];
  assign pec_required_out = q.spec[SPEC_PEC_BIT];
  assign droop_slope_select_out = q.spec[SPEC_DROOP_BIT];
  assign adaptive_ramp_loop_comp_out = q.spec[SPEC_ART_BIT];
  assign dynamic_bus_voltage_out = q.spec[SPEC_DBV_BIT];
  assign feed_forward_params_out = q.ff;
  assign output_current_out = cif.result;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_spec_write;
    ce_in && acc_valid_in && acc_write_in
      && acc_code_in == CODE_SPECIAL_OPTIONS && acc_index_in == 3'h0;
  endsequence

  property p_pec;
    @(posedge clock_in) disable iff (!rst_n_in)
    s_spec_write |=> pec_required_out == $past(acc_wdata_in[7]);
  endproperty
  a_pec: assert property (p_pec)
    else $error("Packet error check bit not taken from write");

  property p_droop;
    @(posedge clock_in) disable iff (!rst_n_in)
    s_spec_write |=> droop_slope_select_out == $past(acc_wdata_in[5]);
  endproperty
  a_droop: assert property (p_droop)
    else $error("Droop slope bit not taken from write");

  property p_art;
    @(posedge clock_in) disable iff (!rst_n_in)
    s_spec_write |=> adaptive_ramp_loop_comp_out == $past(acc_wdata_in[3]);
  endproperty
  a_art: assert property (p_art)
    else $error("Adaptive ramp bit not taken from write");

  property p_dbv;
    @(posedge clock_in) disable iff (!rst_n_in)
    s_spec_write |=> dynamic_bus_voltage_out == $past(acc_wdata_in[2]);
  endproperty
  a_dbv: assert property (p_dbv)
    else $error("Dynamic bus voltage bit not taken from write");

  property p_reserved;
    @(posedge clock_in) disable iff (!rst_n_in)
    q.spec[1:0] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved option bits became set");

  property p_temp_ro;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && acc_valid_in && acc_write_in
      && acc_code_in == CODE_INTERNAL_TEMP_OFFSET) |=> acc_err_out;
  endproperty
  a_temp_ro: assert property (p_temp_ro)
    else $error("Write to temperature offset not refused");

  property p_cal_read;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && acc_valid_in && !acc_write_in && acc_index_in == 3'h2
      && acc_code_in == CODE_EXTERNAL_SENSOR_CAL)
      |=> acc_ack_out && acc_rdata_out == SENSOR_CAL[23:16];
  endproperty
  a_cal_read: assert property (p_cal_read)
    else $error("Calibration slope byte read wrong");

  property p_and;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && q.rctl[RCTL_EN_BIT] && q.rctl[RCTL_AND_BIT] && !base_on)
      |=> !output_enable_out;
  endproperty
  a_and: assert property (p_and)
    else $error("AND combine enabled output without base on");

  property p_disabled;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && !q.rctl[RCTL_EN_BIT])
      |=> output_enable_out == $past(base_on);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Disabled remote pin affected output enable");

  property p_or_pol;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && q.rctl[RCTL_EN_BIT] && !q.rctl[RCTL_AND_BIT]
      && q.rc_sync[1] == q.rctl[RCTL_POL_BIT]) |=> output_enable_out;
  endproperty
  a_or_pol: assert property (p_or_pol)
    else $error("Active remote pin did not enable output");

  property p_byte_only;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && acc_valid_in && acc_index_in != 3'h0
      && acc_code_in == CODE_REMOTE_PIN_CONTROL) |=> acc_err_out;
  endproperty
  a_byte_only: assert property (p_byte_only)
    else $error("Multi-byte access to remote control not refused");

  property p_ff_hold;
    @(posedge clock_in) disable iff (!rst_n_in)
    !(ce_in && acc_valid_in && acc_write_in) |=> $stable(q.ff);
  endproperty
  a_ff_hold: assert property (p_ff_hold)
    else $error("Feed-forward block changed without write");

  c_spec_write: cover property (@(posedge clock_in) s_spec_write);
  c_and_mode: cover property (@(posedge clock_in)
    q.rctl[RCTL_EN_BIT] && q.rctl[RCTL_AND_BIT] && output_enable_out);
  c_ff_read: cover property (@(posedge clock_in)
    acc_valid_in && !acc_write_in && acc_index_in == 3'h3
    && acc_code_in == CODE_FEED_FORWARD_PARAMS);
endmodule

// ### converter_mfr_config_bank_tb.sv
// Self-checking bench for the configuration command bank
`timescale 1ns/100ps
module converter_mfr_config_bank_tb;
  import mfr_config_pkg::*;
  // Read-only contents; values are arbitrary
  localparam logic [15:0] TOFS = 16'h1234;
  localparam logic [31:0] SCAL = 32'h89ab_cdef;
  localparam logic [47:0] TCOEF = 48'h0a_50_14_28_5678;
  logic clock_in, rst_n_in, ce_in;
  logic acc_valid, acc_write, acc_ack, acc_err;
  logic [7:0] acc_code, acc_wdata, acc_rdata;
  logic [2:0] acc_index;
  logic op_on, ctrl_pin, rc_pin, oe, quick, pec, droop, art, dynamic_bus_voltage;
  logic [31:0] ff_out;
  logic [7:0] temp;
  logic [15:0] cur, cur_out;
  int err_total = 0;
  int samples_checked = 0;

  converter_mfr_config_bank #(.TEMP_OFFSET(TOFS), .SENSOR_CAL(SCAL),
    .TEMP_COEFF(TCOEF)) converter_mfr_config_bank_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .acc_valid_in(acc_valid), .acc_write_in(acc_write),
    .acc_code_in(acc_code), .acc_index_in(acc_index),
    .acc_wdata_in(acc_wdata), .acc_ack_out(acc_ack),
    .acc_err_out(acc_err), .acc_rdata_out(acc_rdata),
    .operation_on_in(op_on), .ctrl_pin_in(ctrl_pin),
    .primary_remote_pin_in(rc_pin), .output_enable_out(oe),
    .quick_off_out(quick), .pec_required_out(pec),
    .droop_slope_select_out(droop),
    .adaptive_ramp_loop_comp_out(art),
    .dynamic_bus_voltage_out(dynamic_bus_voltage), .feed_forward_params_out(ff_out),
    .temperature_in(temp), .current_sense_in(cur),
    .output_current_out(cur_out));

  host_model host_model_inst (
    .clock_in(clock_in), .acc_valid_out(acc_valid),
    .acc_write_out(acc_write), .acc_code_out(acc_code),
    .acc_index_out(acc_index), .acc_wdata_out(acc_wdata),
    .acc_ack_in(acc_ack), .acc_err_in(acc_err),
    .acc_rdata_in(acc_rdata));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time,
        seen, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [7:0] code,
    input int idx, input logic [7:0] wd, input logic [7:0] exp,
    input logic exp_err);
    logic ack, err;
    logic [7:0] rd;
    host_model_inst.xfer(wr, code, 3'(idx), wd, ack, err, rd);
    check({ack, err}, {1'b1, exp_err});
    check(rd, (wr | exp_err) ? 8'h00 : exp);
  endtask

  function automatic logic [15:0] comp_exp(input logic [7:0] t,
    input logic [15:0] r);
    logic [7:0] f;
    logic [24:0] s;
    f = (t > TCOEF[39:32]) ? TCOEF[47:40] :
      ((t > TCOEF[23:16]) ? TCOEF[31:24] : 8'h00);
    s = {9'h000, r} + ((25'(r) * 25'(f)) >> 8);
    return (s[24:16] != 9'h000) ? 16'hffff : s[15:0];
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  initial
  begin
    #500us;
    err_total++;
    wrap_up();
  end

  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial
  begin
    logic [7:0] opts [6];
    logic [7:0] tv [5];
    logic [15:0] cv [5];
    logic [31:0] ffv;
    logic [7:0] v;
    logic ack, err, base, act, exp;
    logic [7:0] rd;
    opts = '{8'hff, 8'h80, 8'h20, 8'h08, 8'h04, 8'h03};
    tv = '{8'h28, 8'h29, 8'h50, 8'h51, 8'h51};
    cv = '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'hffff};
    ffv = 32'hc3a5_5a3c;
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    op_on = 1'b0;
    ctrl_pin = 1'b0;
    rc_pin = 1'b0;
    temp = 8'h00;
    cur = 16'h0000;
    repeat (10) @(negedge clock_in);
    rst_n_in = 1'b1;
    // Reset state
    check({pec, droop, art, dynamic_bus_voltage, oe, quick, ff_out}, 38'h0);
    access(1'b0, CODE_SPECIAL_OPTIONS, 0, 8'h00, 8'h00, 1'b0);
    access(1'b0, CODE_REMOTE_PIN_CONTROL, 0, 8'h00, 8'h00, 1'b0);
    // Option bits, reserved bits read back zero
    foreach (opts[i])
    begin
      v = opts[i];
      access(1'b1, CODE_SPECIAL_OPTIONS, 0, v, 8'h00, 1'b0);
      access(1'b0, CODE_SPECIAL_OPTIONS, 0, 8'h00, v & 8'hac, 1'b0);
      check({pec, droop, art, dynamic_bus_voltage}, {v[7], v[5], v[3], v[2]});
    end
    // Frozen clock enable ignores a request
    @(negedge clock_in);
    ce_in = 1'b0;
    host_model_inst.xfer(1'b1, CODE_SPECIAL_OPTIONS, 3'h0, 8'hff, ack,
      err, rd);
    check(ack, 1'b0);
    ce_in = 1'b1;
    access(1'b0, CODE_SPECIAL_OPTIONS, 0, 8'h00, 8'h00, 1'b0);
    // Read-only contents, little-endian bytes
    for (int i = 0; i < 2; i++)
      access(1'b0, CODE_INTERNAL_TEMP_OFFSET, i, 8'h00, TOFS[8*i+:8],
        1'b0);
    for (int i = 0; i < 4; i++)
      access(1'b0, CODE_EXTERNAL_SENSOR_CAL, i, 8'h00, SCAL[8*i+:8],
        1'b0);
    for (int i = 0; i < 6; i++)
      access(1'b0, CODE_CURRENT_SENSE_COMP, i, 8'h00, TCOEF[8*i+:8],
        1'b0);
    // Refusals: past the length, writes to read-only, unknown code
    access(1'b0, CODE_INTERNAL_TEMP_OFFSET, 2, 8'h00, 8'h00, 1'b1);
    access(1'b0, CODE_EXTERNAL_SENSOR_CAL, 4, 8'h00, 8'h00, 1'b1);
    access(1'b0, CODE_CURRENT_SENSE_COMP, 6, 8'h00, 8'h00, 1'b1);
    access(1'b0, CODE_SPECIAL_OPTIONS, 1, 8'h00, 8'h00, 1'b1);
    access(1'b1, CODE_REMOTE_PIN_CONTROL, 1, 8'hff, 8'h00, 1'b1);
    access(1'b1, CODE_INTERNAL_TEMP_OFFSET, 0, 8'hff, 8'h00, 1'b1);
    access(1'b1, CODE_EXTERNAL_SENSOR_CAL, 3, 8'hff, 8'h00, 1'b1);
    access(1'b1, CODE_CURRENT_SENSE_COMP, 5, 8'hff, 8'h00, 1'b1);
    access(1'b0, 8'he4, 0, 8'h00, 8'h00, 1'b1);
    access(1'b0, CODE_INTERNAL_TEMP_OFFSET, 0, 8'h00, TOFS[7:0], 1'b0);
    access(1'b0, CODE_CURRENT_SENSE_COMP, 5, 8'h00, TCOEF[47:40], 1'b0);
    // Feed-forward block, byte by byte
    for (int i = 0; i < 4; i++)
      access(1'b1, CODE_FEED_FORWARD_PARAMS, i, ffv[8*i+:8], 8'h00,
        1'b0);
    for (int i = 0; i < 4; i++)
      access(1'b0, CODE_FEED_FORWARD_PARAMS, i, 8'h00, ffv[8*i+:8],
        1'b0);
    check(ff_out, ffv);
    access(1'b1, CODE_REMOTE_PIN_CONTROL, 0, 8'hff, 8'h00, 1'b0);
    access(1'b0, CODE_REMOTE_PIN_CONTROL, 0, 8'h00, 8'h17,
      1'b0);
    // Every remote configuration against every source level
    for (int k = 0; k < 128; k++)
    begin
      v = {3'h0, k[6], 1'b0, k[5], k[4], k[3]};
      access(1'b1, CODE_REMOTE_PIN_CONTROL, 0, v, 8'h00, 1'b0);
      op_on = k[2];
      ctrl_pin = k[1];
      rc_pin = k[0];
      // Two synchroniser stages plus the output register
      repeat (5) @(negedge clock_in);
      base = k[2] & k[1];
      act = (k[0] == k[4]);
      exp = !k[5] ? base : (k[6] ? (base & act) : (base | act));
      check(oe, exp);
      check(quick, k[3]);
    end
    // Current compensation around both temperature levels
    for (int k = 0; k < 5; k++)
    begin
      temp = tv[k];
      cur = cv[k];
      repeat (2) @(negedge clock_in);
      check(cur_out, comp_exp(tv[k], cv[k]));
    end
    wrap_up();
  end
endmodule

// ### current_sense_comp.sv
// Temperature-stepped gain applied to the current-sense reading
`timescale 1ns/100ps
module current_sense_comp
  import mfr_config_pkg::*;
#(
  parameter int W = 16
)
(
  // Clock and control
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Compensation link
  comp_if.comp link
);
  typedef struct packed {
    logic [W-1:0] result;
  } comp_state_t;

  comp_state_t q, d;
  logic [7:0] factor;
  logic [W+7:0] prod;
  logic [W:0] sum;

  always_comb
  begin
    d = q;
    factor = 8'h00;
    // Highest level reached wins
    if (link.temp > link.level2)
      factor = link.factor2;
    else if (link.temp > link.level1)
      factor = link.factor1;
    prod = link.raw * factor;
    sum = {1'b0, link.raw} + {1'b0, prod[W+7:COMP_FACTOR_SHIFT]};
    // Saturate rather than wrap on a large gain
    if (ce_in)
      d.result = sum[W] ? {W{1'b1}} : sum[W-1:0];
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      q <= '0;
    else
      q <= d;
  end

  assign link.result = q.result;

  property p_comp_unity;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && link.temp <= link.level1 && link.temp <= link.level2)
      |=> link.result == $past(link.raw);
  endproperty
  a_comp_unity: assert property (p_comp_unity)
    else $error("Below both levels the reading must pass unchanged");

  property p_comp_raise;
    @(posedge clock_in) disable iff (!rst_n_in)
    (ce_in && link.temp > link.level2 && link.factor2 != 8'h00
      && link.raw >= W'(256))
      |=> (($past(link.raw) == {W{1'b1}}) ? link.result == {W{1'b1}}
        : link.result > $past(link.raw));
  endproperty
  a_comp_raise: assert property (p_comp_raise)
    else $error("Above level two the factor must raise the reading");

  c_comp_high: cover property (@(posedge clock_in)
    ce_in && link.temp > link.level2);
endmodule

// ### host_model.sv
// Bus host model issuing single-byte command accesses
`timescale 1ns/100ps
module host_model
(
  // Clock
  input wire logic clock_in,
  // Access request
  output logic acc_valid_out,
  output logic acc_write_out,
  output logic [7:0] acc_code_out,
  output logic [2:0] acc_index_out,
  output logic [7:0] acc_wdata_out,
  // Access answer
  input wire logic acc_ack_in,
  input wire logic acc_err_in,
  input wire logic [7:0] acc_rdata_in
);
  initial
  begin
    acc_valid_out = 1'b0;
    acc_write_out = 1'b0;
    acc_code_out = 8'h00;
    acc_index_out = 3'h0;
    acc_wdata_out = 8'h00;
  end

  // -------------------------------------------------------------
  // Single byte transfer
  // -------------------------------------------------------------
  // Valid lasts one cycle; an idle cycle follows so the strobe is
  // never raised in the step that lowered it
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [2:0] idx, input logic [7:0] wd,
    output logic ack, output logic err, output logic [7:0] rd);
    @(negedge clock_in);
    acc_valid_out = 1'b1;
    acc_write_out = wr;
    acc_code_out = code;
    acc_index_out = idx;
    acc_wdata_out = wd;
    @(negedge clock_in);
    ack = acc_ack_in;
    err = acc_err_in;
    rd = acc_rdata_in;
    acc_valid_out = 1'b0;
    // Released data shows garbage, not the last byte
    acc_wdata_out = ~wd;
    acc_code_out = ~code;
  endtask
endmodule

// ### mfr_config_pkg.sv
// Constants for the manufacturer configuration command bank
package mfr_config_pkg;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_SPECIAL_OPTIONS = 8'he0;
  localparam logic [7:0] CODE_INTERNAL_TEMP_OFFSET = 8'he1;
  localparam logic [7:0] CODE_EXTERNAL_SENSOR_CAL = 8'he2;
  localparam logic [7:0] CODE_REMOTE_PIN_CONTROL = 8'he3;
  localparam logic [7:0] CODE_FEED_FORWARD_PARAMS = 8'he6;
  localparam logic [7:0] CODE_CURRENT_SENSE_COMP = 8'he7;
  // ---------------------------------------------------------------
  // Transfer lengths in bytes
  // ---------------------------------------------------------------
  localparam logic [2:0] LEN_SPECIAL_OPTIONS = 3'h1;
  localparam logic [2:0] LEN_INTERNAL_TEMP_OFFSET = 3'h2;
  localparam logic [2:0] LEN_EXTERNAL_SENSOR_CAL = 3'h4;
  localparam logic [2:0] LEN_REMOTE_PIN_CONTROL = 3'h1;
  localparam logic [2:0] LEN_FEED_FORWARD_PARAMS = 3'h4;
  localparam logic [2:0] LEN_CURRENT_SENSE_COMP = 3'h6;
  // ---------------------------------------------------------------
  // Special options fields
  // ---------------------------------------------------------------
  localparam int SPEC_PEC_BIT = 7;
  localparam int SPEC_DROOP_BIT = 5;
  localparam int SPEC_ART_BIT = 3;
  localparam int SPEC_DBV_BIT = 2;
  localparam logic [7:0] SPEC_WRITE_MASK = 8'hac;
  localparam logic [7:0] SPEC_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Remote pin control fields
  // ---------------------------------------------------------------
  localparam int RCTL_AND_BIT = 4;
  localparam int RCTL_EN_BIT = 2;
  localparam int RCTL_POL_BIT = 1;
  localparam int RCTL_QUICK_BIT = 0;
  localparam logic [7:0] RCTL_WRITE_MASK = 8'h17;
  localparam logic [7:0] RCTL_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Feed-forward and read-only defaults
  // ---------------------------------------------------------------
  localparam logic [31:0] FEED_FORWARD_RESET = 32'h0000_0000;
  localparam logic [15:0] TEMP_OFFSET_DEFAULT = 16'h0000;
  localparam logic [31:0] SENSOR_CAL_DEFAULT = 32'h0100_0000;
  localparam logic [47:0] TEMP_COEFF_DEFAULT = 48'h08_64_04_50_0000;
  // Compensation factor is a gain in 1/256 steps added to unity
  localparam int COMP_FACTOR_SHIFT = 8;
endpackage
